//--- acsf_cmd_frames.sv
// Command frame decoder: pin functions, channel scan, alarm thresholds, output word
// How it works
// - Nibble 1001 stores bits 9..6 as the last channel of the scan.
// - In auto 2 mode the scan counter runs from zero up to the last channel, then wraps.
// - Nibble 0000 keeps all settings; auto modes advance, manual keeps its channel.
// - Results leave as 12-bit straight binary codes, unchanged.
// - General outputs take last frame's data at each chip select fall.
// - General inputs are caught at chip select fall, sent when reading enabled.
// - Nibble 0100 loads the pin function register from the low twelve bits.
// - Bit 9 of a pin function frame resets all decoder state, but not the result buffer, in the next frame.
// - Bit 8 makes pin three power down; bit 7 makes pin two range.
// - Bits 6..4 route high, low or either alarm onto pins zero and one.
// - Pins without special use follow their direction bit: one drives.
// - A high and a low threshold per channel, four groups of four.
// - One entry frame, then one threshold written per frame.
// - Fewer writes allowed; the sequence ends after the first exit bit.
// - During sequences scanning goes on; range and output data stay.
// - Entry nibble 11bb selects alarm group bb.
// - Bits 15..14 pick the channel in the group, bit 13 high or low.
// - Without exit bit every further frame is taken as threshold data.
// - Ten-bit thresholds compare with the result's upper ten bits.
`timescale 1ns/1ns
`include "acsf_defs.svh"
module acsf_cmd_frames (
  // System
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  // Serial frame pins
  input  wire logic                         sclkPin,
  input  wire logic                         chipSelectN,
  input  wire logic                         cmdBitIn,
  output      logic                         sdo,
  // General-purpose pins
  input  wire logic [3:0]                   gpPinIn,
  output      acsf_pkg::acsf_pins_type      gpPin,
  // Converter core
  input  wire logic                         resultValid,
  input  wire acsf_pkg::acsf_result_type    resultWord,
  output      logic                         resultReady,
  output      logic                         convStart,
  output      logic [3:0]                   convChannel,
  output      logic                         rangeSel,
  output      logic                         powerDown
);
  typedef struct packed {
    acsf_pkg::acsf_mode_type    mode;
    acsf_pkg::acsf_seq_type     seq;
    logic [1:0]                 group;
    logic [3:0]                 lastChannel;
    logic [3:0]                 channel;
    acsf_pkg::acsf_pin_cfg_type cfg;
    logic                       rangeBit;
    logic                       pdBit;
    logic                       gpInputRead;
    logic                       resetPending;
    logic [3:0]                 gpOutputNext;
    logic [3:0]                 gpOutput;
    logic [3:0]                 pinS1;
    logic [3:0]                 pinS2;
    logic [15:0][9:0]           highThr;
    logic [15:0][9:0]           lowThr;
    logic                       alarmHigh;
    logic                       alarmLow;
    logic                       txLoad;
    logic [15:0]                txWord;
    logic                       convStart;
    logic [3:0]                 convChannel;
    acsf_pkg::acsf_pins_type    pins;
    logic                       rangeSel;
    logic                       powerDown;
  } acsf_main_state_type;

  localparam acsf_main_state_type RESET_STATE = '{
    mode:        acsf_pkg::MODE_MANUAL,
    seq:         acsf_pkg::SEQ_IDLE,
    lastChannel: `ACSF_LAST_CH_RESET,
    cfg:         `ACSF_PIN_CFG_RESET,
    highThr:     {16{`ACSF_HIGH_THR_RESET}},
    lowThr:      {16{`ACSF_LOW_THR_RESET}},
    default:     '0
  };

  // Pin drive: a special function overrides the plain direction bit
  function automatic logic [1:0] pinDrive(input logic special, input logic specOe,
                                          input logic specLvl, input logic isOut,
                                          input logic lvl);
    if (special) begin
      pinDrive = {specOe, specLvl};
    end else begin
      pinDrive = {isOut, lvl};
    end
  endfunction

  acsf_main_state_type       q;
  acsf_main_state_type       d;
  acsf_pkg::acsf_frame_type  fr;
  acsf_pkg::acsf_result_type res;
  acsf_pkg::acsf_mode_type   newMode;
  logic                      bufValid;
  logic [15:0]               bufWord;
  logic                      popNow;
  logic [15:0]               w;
  logic [3:0]                idx;
  logic                      pin0Alarm;
  logic                      pin0Lvl;
  logic                      pin1Alarm;

  acsf_frame_port u_port (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .sclkPin     (sclkPin),
    .chipSelectN (chipSelectN),
    .cmdBitIn    (cmdBitIn),
    .sdo         (sdo),
    .txLoad      (q.txLoad),
    .txWord      (q.txWord),
    .frame       (fr)
  );

  // Results wait here until the next frame opens, so a slow host loses none
  acsf_pair_buffer #(
    .WIDTH (16),
    .DEPTH (2)
  ) u_buf (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .inValid  (resultValid),
    .inData   (resultWord),
    .inReady  (resultReady),
    .outValid (bufValid),
    .outData  (bufWord),
    .outReady (popNow)
  );

  always_comb begin
    // A pending soft reset lands as the next frame opens
    d = (fr.start && q.resetPending) ? RESET_STATE : q;
    d.pinS1 = gpPinIn;
    d.pinS2 = q.pinS1;
    d.txLoad = 1'b0;
    d.convStart = 1'b0;
    popNow = 1'b0;
    res = acsf_pkg::acsf_result_type'(bufWord);
    newMode = q.mode;
    w = fr.word;
    idx = {q.group, w[`ACSF_ALM_CH_HI:`ACSF_ALM_CH_LO]};
    if (fr.start) begin
      d.gpOutput = d.gpOutputNext;
      d.convStart = 1'b1;
      d.convChannel = d.channel;
      case (d.mode)
        acsf_pkg::MODE_AUTO2: begin
          d.channel = (d.channel == d.lastChannel) ? 4'h0 : d.channel + 4'h1;
        end
        acsf_pkg::MODE_AUTO1: begin
          d.channel = d.channel + 4'h1;
        end
        default: begin
          d.channel = d.channel;
        end
      endcase
      popNow = bufValid;
      if (!bufValid) begin
        res = '0;
      end else begin
        d.alarmHigh = res.code[11:2] > d.highThr[res.channel];
        d.alarmLow = res.code[11:2] < d.lowThr[res.channel];
      end
      // Code goes out as the core delivered it
      d.txWord = {(d.gpInputRead ? q.pinS2 : res.channel), res.code};
      d.txLoad = 1'b1;
    end
    if (fr.done && fr.whole) begin
      case (q.seq)
        acsf_pkg::SEQ_ALARM: begin
          if (w[`ACSF_ALM_HIGH_BIT]) begin
            d.highThr[idx] = w[`ACSF_THR_HI:0];
          end else begin
            d.lowThr[idx] = w[`ACSF_THR_HI:0];
          end
          if (w[`ACSF_ALM_EXIT_BIT]) begin
            d.seq = acsf_pkg::SEQ_IDLE;
          end
        end
        acsf_pkg::SEQ_AUTO1: begin
          // Second frame of that sequence only fills a register not kept here
          d.seq = acsf_pkg::SEQ_IDLE;
        end
        acsf_pkg::SEQ_IDLE: begin
          case (w[15:12])
            `ACSF_CMD_CONTINUE: begin
              d.seq = acsf_pkg::SEQ_IDLE;
            end
            `ACSF_CMD_AUTO2_PROG: begin
              d.lastChannel = w[`ACSF_LAST_CH_HI:`ACSF_LAST_CH_LO];
              if (q.mode == acsf_pkg::MODE_AUTO2) begin
                d.channel = 4'h0;
              end
            end
            `ACSF_CMD_PIN_CFG: begin
              d.cfg = w[11:0];
              d.resetPending = w[`ACSF_SOFT_RESET_BIT];
            end
            `ACSF_CMD_AUTO1_PROG: begin
              d.seq = acsf_pkg::SEQ_AUTO1;
            end
            `ACSF_CMD_MANUAL, `ACSF_CMD_AUTO1, `ACSF_CMD_AUTO2: begin
              case (w[13:12])
                2'h1: newMode = acsf_pkg::MODE_MANUAL;
                2'h2: newMode = acsf_pkg::MODE_AUTO1;
                default: newMode = acsf_pkg::MODE_AUTO2;
              endcase
              d.mode = newMode;
              if (newMode == acsf_pkg::MODE_MANUAL) begin
                d.channel = w[`ACSF_MAN_CH_HI:`ACSF_MAN_CH_LO];
              end else if (newMode != q.mode || w[`ACSF_CH_RESTART_BIT]) begin
                d.channel = 4'h0;
              end
              if (w[`ACSF_MODE_WRITE_BIT]) begin
                d.rangeBit = w[`ACSF_RANGE_BIT];
                d.pdBit = w[`ACSF_PDOWN_BIT];
                d.gpInputRead = w[`ACSF_GPI_READ_BIT];
                d.gpOutputNext = w[3:0];
              end
            end
            default: begin
              if (w[15:14] == `ACSF_ALARM_PREFIX) begin
                d.seq = acsf_pkg::SEQ_ALARM;
                d.group = w[13:12];
              end
            end
          endcase
        end
        default: begin
          d.seq = acsf_pkg::SEQ_IDLE;
        end
      endcase
    end
    // Alarm routing onto pins zero and one, all active high
    pin0Alarm = q.cfg.alarmFn[0] || q.cfg.alarmFn[1];
    pin0Lvl = q.cfg.alarmFn[0] ? (q.alarmHigh | q.alarmLow) : q.alarmHigh;
    pin1Alarm = !q.cfg.alarmFn[0] && q.cfg.alarmFn[2];
    {d.pins.oe[0], d.pins.out[0]} = pinDrive(pin0Alarm, 1'b1, pin0Lvl,
                                             q.cfg.dirOut[0], q.gpOutput[0]);
    {d.pins.oe[1], d.pins.out[1]} = pinDrive(pin1Alarm, 1'b1, q.alarmLow,
                                             q.cfg.dirOut[1], q.gpOutput[1]);
    {d.pins.oe[2], d.pins.out[2]} = pinDrive(q.cfg.rangePin, 1'b0, 1'b0,
                                             q.cfg.dirOut[2], q.gpOutput[2]);
    {d.pins.oe[3], d.pins.out[3]} = pinDrive(q.cfg.pdPin, 1'b0, 1'b0,
                                             q.cfg.dirOut[3], q.gpOutput[3]);
    d.rangeSel = q.cfg.rangePin ? q.pinS2[2] : q.rangeBit;
    d.powerDown = q.cfg.pdPin ? q.pinS2[3] : q.pdBit;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign gpPin = q.pins;
  assign convStart = q.convStart;
  assign convChannel = q.convChannel;
  assign rangeSel = q.rangeSel;
  assign powerDown = q.powerDown;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  lastChanStore_a: assert property (
    fr.done && fr.whole && q.seq == acsf_pkg::SEQ_IDLE && w[15:12] == 4'h9
    |=> q.lastChannel == $past(w[9:6]))
    else $error("last channel not stored");
  scanWrap_a: assert property (
    fr.start && !q.resetPending && q.mode == acsf_pkg::MODE_AUTO2
    && q.channel == q.lastChannel |=> q.channel == 4'h0 && q.convChannel == $past(q.channel))
    else $error("scan did not wrap after last channel");
  scanStep_a: assert property (
    fr.start && !q.resetPending && q.mode == acsf_pkg::MODE_AUTO2
    && q.channel != q.lastChannel |=> q.channel == $past(q.channel) + 4'h1)
    else $error("scan did not step by one");
  continueKeep_a: assert property (
    fr.done && fr.whole && q.seq == acsf_pkg::SEQ_IDLE && w[15:12] == 4'h0
    |=> $stable(q.cfg) && $stable(q.mode) && $stable(q.lastChannel) && $stable(q.rangeBit))
    else $error("continue frame changed a setting");
  resultCode_a: assert property (
    fr.start && bufValid |=> q.txLoad && q.txWord[11:0] == $past(bufWord[11:0]))
    else $error("result code altered on the way out");
  gpoRefresh_a: assert property (
    fr.start && !q.resetPending |=> q.gpOutput == $past(q.gpOutputNext) ##1
    gpPin.out[3] == (q.cfg.pdPin ? 1'b0 : q.gpOutput[3]))
    else $error("general output not refreshed at frame start");
  gpiRead_a: assert property (
    fr.start && !q.resetPending && q.gpInputRead |=> q.txWord[15:12] == $past(q.pinS2))
    else $error("caught input levels not sent");
  pinCfgLoad_a: assert property (
    fr.done && fr.whole && q.seq == acsf_pkg::SEQ_IDLE && w[15:12] == 4'h4
    |=> q.cfg == $past(w[11:0]))
    else $error("pin function register not loaded");
  softReset_a: assert property (
    fr.start && q.resetPending
    |=> q.cfg == `ACSF_PIN_CFG_RESET && q.lastChannel == `ACSF_LAST_CH_RESET && !q.resetPending)
    else $error("soft reset not applied at next frame");
  pdPin_a: assert property (
    q.cfg.pdPin && $stable(q.cfg) && !fr.done && !fr.start
    |=> !gpPin.oe[3] ##1 powerDown == $past(q.pinS2[3]))
    else $error("pin three not acting as power down input");
  highAlarmPin_a: assert property (
    q.cfg.alarmFn == `ACSF_FN_HIGH |=> gpPin.oe[0] && gpPin.out[0] == $past(q.alarmHigh))
    else $error("pin zero does not carry the high alarm");
  bothAlarmPins_a: assert property (
    q.cfg.alarmFn == `ACSF_FN_BOTH |=> gpPin.oe[1] && gpPin.out[1] == $past(q.alarmLow))
    else $error("pin one does not carry the low alarm");
  dirOut_a: assert property (
    q.cfg.alarmFn == 3'h0 && !q.cfg.rangePin |=> gpPin.oe[2] == $past(q.cfg.dirOut[2]))
    else $error("plain pin ignores its direction bit");
  thrWrite_a: assert property (
    fr.done && fr.whole && q.seq == acsf_pkg::SEQ_ALARM && w[13]
    |=> q.highThr[$past(idx)] == $past(w[9:0]))
    else $error("high threshold not written");
  alarmExit_a: assert property (
    fr.done && fr.whole && q.seq == acsf_pkg::SEQ_ALARM && w[12] |=> q.seq == acsf_pkg::SEQ_IDLE)
    else $error("alarm sequence not left on exit bit");
  alarmStay_a: assert property (
    fr.done && fr.whole && q.seq == acsf_pkg::SEQ_ALARM && !w[12]
    |=> q.seq == acsf_pkg::SEQ_ALARM && $stable(q.group))
    else $error("alarm sequence left without exit bit");
  seqHold_a: assert property (
    fr.done && q.seq != acsf_pkg::SEQ_IDLE |=> $stable(q.rangeBit) && $stable(q.gpOutputNext))
    else $error("range or output data changed during a sequence");
  alarmEnter_a: assert property (
    fr.done && fr.whole && q.seq == acsf_pkg::SEQ_IDLE && w[15:14] == 2'h3
    |=> q.seq == acsf_pkg::SEQ_ALARM && q.group == $past(w[13:12]))
    else $error("alarm group not entered");
endmodule

//--- acsf_defs.svh
// Command codes, field positions, reset values and bit counts of the command frame decoder
`ifndef ACSF_DEFS_SVH
`define ACSF_DEFS_SVH
`define ACSF_FRAME_BITS      5'h10
`define ACSF_BIT_CNT_MAX     5'h1F
`define ACSF_CMD_CONTINUE    4'h0
`define ACSF_CMD_MANUAL      4'h1
`define ACSF_CMD_AUTO1       4'h2
`define ACSF_CMD_AUTO2       4'h3
`define ACSF_CMD_PIN_CFG     4'h4
`define ACSF_CMD_AUTO1_PROG  4'h8
`define ACSF_CMD_AUTO2_PROG  4'h9
`define ACSF_ALARM_PREFIX    2'h3
`define ACSF_LAST_CH_HI      9
`define ACSF_LAST_CH_LO      6
`define ACSF_SOFT_RESET_BIT  9
`define ACSF_MODE_WRITE_BIT  11
`define ACSF_CH_RESTART_BIT  10
`define ACSF_MAN_CH_HI       10
`define ACSF_MAN_CH_LO       7
`define ACSF_RANGE_BIT       6
`define ACSF_PDOWN_BIT       5
`define ACSF_GPI_READ_BIT    4
`define ACSF_ALM_CH_HI       15
`define ACSF_ALM_CH_LO       14
`define ACSF_ALM_HIGH_BIT    13
`define ACSF_ALM_EXIT_BIT    12
`define ACSF_THR_HI          9
`define ACSF_FN_HIGH         3'h2
`define ACSF_FN_BOTH         3'h6
`define ACSF_HIGH_THR_RESET  10'h3FF
`define ACSF_LOW_THR_RESET   10'h000
`define ACSF_LAST_CH_RESET   4'hF
`define ACSF_PIN_CFG_RESET   12'h000
`endif

//--- acsf_frame_port.sv
// Serial pin front end: synchronisers, edge finding, frame shift in and out
`timescale 1ns/1ns
`include "acsf_defs.svh"
module acsf_frame_port (
  // System
  input  wire logic           ref_clk,
  input  wire logic           nrst,
  // Serial pins
  input  wire logic           sclkPin,
  input  wire logic           chipSelectN,
  input  wire logic           cmdBitIn,
  output      logic           sdo,
  // Frame side
  input  wire logic           txLoad,
  input  wire logic [15:0]    txWord,
  output acsf_pkg::acsf_frame_type frame
);
  typedef struct packed {
    logic [2:0]               s1;
    logic [2:0]               s2;
    logic                     sclkOld;
    logic                     csOld;
    logic [15:0]              rx;
    logic [15:0]              tx;
    logic [4:0]               bits;
    logic                     sdo;
    acsf_pkg::acsf_frame_type frame;
  } acsf_port_state_type;

  acsf_port_state_type q;
  acsf_port_state_type d;
  logic                sclkRise;
  logic                sclkFall;
  logic                csFall;
  logic                csRise;

  always_comb begin
    d = q;
    d.s1 = {sclkPin, chipSelectN, cmdBitIn};
    d.s2 = q.s1;
    d.sclkOld = q.s2[2];
    d.csOld = q.s2[1];
    d.frame.start = 1'b0;
    d.frame.done = 1'b0;
    sclkRise = q.s2[2] & ~q.sclkOld;
    sclkFall = ~q.s2[2] & q.sclkOld;
    csFall = ~q.s2[1] & q.csOld;
    csRise = q.s2[1] & ~q.csOld;
    if (csFall) begin
      d.bits = 5'h00;
      d.frame.start = 1'b1;
    end else if (!q.s2[1] && sclkRise) begin
      // Most significant bit arrives first
      d.rx = {q.rx[14:0], q.s2[0]};
      if (q.bits != `ACSF_BIT_CNT_MAX) begin
        d.bits = q.bits + 5'h01;
      end
    end
    if (csRise) begin
      d.frame.done = 1'b1;
      d.frame.whole = (q.bits == `ACSF_FRAME_BITS);
      d.frame.word = q.rx;
    end
    if (txLoad) begin
      d.tx = txWord;
      d.sdo = txWord[15];
    end else if (!q.s2[1] && sclkFall) begin
      d.tx = {q.tx[14:0], 1'b0};
      d.sdo = q.tx[14];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{s1: 3'h2, s2: 3'h2, csOld: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign sdo = q.sdo;
  assign frame = q.frame;

  frameWhole_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    csRise && q.bits == 5'h10 |=> frame.done && frame.whole)
    else $error("sixteen bit frame not reported whole");
endmodule

//--- acsf_host_model.sv
// Host model: mode 0 frames of 16 bits on a 160 ns serial clock
`timescale 1ns/1ns
module acsf_host_model (
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output      logic sclkPin,
  output      logic chipSelectN,
  output      logic cmdBitIn,
  input  wire logic sdo
);
  initial begin
    sclkPin = 1'b0;
    chipSelectN = 1'b1;
    cmdBitIn = 1'b1;
  end
  task automatic send(input logic [15:0] w, output logic [15:0] r);
    @(posedge ref_clk) chipSelectN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      cmdBitIn <= w[i];
      repeat (8) @(posedge ref_clk);
      r[i] = sdo;
      sclkPin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      sclkPin <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    chipSelectN <= 1'b1;
    cmdBitIn <= ~w[0];
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

//--- acsf_pair_buffer.sv
// Small valid/ready buffer between the converter core and the serial output
`timescale 1ns/1ns
module acsf_pair_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // System
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             inReady,
  // Drain side
  output      logic             outValid,
  output      logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two and at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 fill;
    logic                        full;
    logic                        empty;
    logic                        ready;
  } acsf_buf_state_type;

  acsf_buf_state_type q;
  acsf_buf_state_type d;
  logic               push;
  logic               pop;

  always_comb begin
    d = q;
    push = inValid & ~q.full;
    pop = outReady & ~q.empty;
    if (push) begin
      d.mem[q.wp] = inData;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.fill = q.fill + (AW+1)'(push) - (AW+1)'(pop);
    d.full = (d.fill == (AW+1)'(DEPTH));
    d.empty = (d.fill == '0);
    // Ready is registered so the top output comes straight from a flip-flop
    d.ready = ~d.full;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{empty: 1'b1, ready: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign inReady = q.ready;
  assign outValid = ~q.empty;
  assign outData = q.mem[q.rp];

  // A stalled drain must keep a full buffer full
  noLoss_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    q.full && !outReady |=> q.full && !inReady)
    else $error("full buffer lost a word while stalled");
endmodule

//--- acsf_pkg.sv
// Types shared by the command frame decoder modules
package acsf_pkg;
  typedef enum logic [2:0] {
    MODE_MANUAL = 3'b001,
    MODE_AUTO1  = 3'b010,
    MODE_AUTO2  = 3'b100
  } acsf_mode_type;
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_AUTO1 = 3'b010,
    SEQ_ALARM = 3'b100
  } acsf_seq_type;
  typedef struct packed {
    logic [3:0]  channel;
    logic [11:0] code;
  } acsf_result_type;
  typedef struct packed {
    logic [1:0] spare;
    logic       softReset;
    logic       pdPin;
    logic       rangePin;
    logic [2:0] alarmFn;
    logic [3:0] dirOut;
  } acsf_pin_cfg_type;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } acsf_pins_type;
  typedef struct packed {
    logic        start;
    logic        done;
    logic        whole;
    logic [15:0] word;
  } acsf_frame_type;
endpackage

//--- tb.sv
// Self-checking bench for the command frame decoder
`timescale 1ns/1ns
module tb;
  logic                      ref_clk = 1'b0, nrst = 1'b0, resultValid = 1'b0;
  logic                      sclkPin, chipSelectN, cmdBitIn, sdo;
  logic                      resultReady, convStart, rangeSel, powerDown;
  logic [3:0]                gpPinIn = 4'h0, convChannel, seenCh, d;
  logic [15:0]               r, expQ[$];
  acsf_pkg::acsf_pins_type   gpPin, seenOut;
  acsf_pkg::acsf_result_type resultWord = '0;
  int                        mismatches = 0, samples_checked = 0, seed = 32'h78AF8186;
  int                        starts = 0, frames = 0;
  acsf_cmd_frames i_dut (.ref_clk(ref_clk), .nrst(nrst), .sclkPin(sclkPin),
    .chipSelectN(chipSelectN), .cmdBitIn(cmdBitIn), .sdo(sdo), .gpPinIn(gpPinIn),
    .gpPin(gpPin), .resultValid(resultValid), .resultWord(resultWord), .resultReady(resultReady),
    .convStart(convStart), .convChannel(convChannel), .rangeSel(rangeSel), .powerDown(powerDown));
  acsf_host_model i_host (.ref_clk(ref_clk), .sclkPin(sclkPin),
    .chipSelectN(chipSelectN), .cmdBitIn(cmdBitIn), .sdo(sdo));
  initial forever #5 ref_clk = ~ref_clk;
  // Conversion start pulses, looked at mid-cycle where they are settled
  always @(negedge ref_clk) if (convStart === 1'b1) starts++;
  // Sampled once the frame start actions have landed, before the first serial edge
  always @(negedge chipSelectN) begin
    repeat (6) @(posedge ref_clk);
    seenCh = convChannel;
    seenOut = gpPin;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) $display("FAIL %s expected %h seen %h", name, exp, seen);
    if (seen !== exp) mismatches++;
  endtask
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic push(input logic [15:0] w);
    @(posedge ref_clk) resultValid <= 1'b1;
    resultWord <= w;
    expQ.push_back(w);
    @(posedge ref_clk) resultValid <= 1'b0;
  endtask
  task automatic frame(input logic [15:0] cmd, input logic gp_input);
    logic [15:0] e;
    e = (expQ.size() > 0) ? expQ.pop_front() : 16'h0000;
    frames++;
    i_host.send(cmd, r);
    if (gp_input)
      e[15:12] = gpPinIn;
    check("sdo word", r, e);
  endtask
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    gpPinIn <= 4'($random(seed));
    d = 4'($random(seed));
    repeat (3) @(posedge ref_clk);
    push(16'($random(seed)));
    push(16'($random(seed)));
    #1 check("ready when full", {15'h0, resultReady}, 16'h0000);
    repeat (3) frame(16'h0000, 1'b0);
    frame(16'h400F, 1'b0);
    frame(16'h1800 | 16'(d), 1'b0);
    frame(16'h0000, 1'b0);
    check("pin drive", 16'(seenOut), {8'h00, d, 4'hF});
    frame(16'h4000, 1'b0);
    frame(16'h1810, 1'b0);
    frame(16'h1800, 1'b1);
    frame(16'h4180, 1'b0);
    check("pin functions", 16'({powerDown, rangeSel}), 16'(gpPinIn[3:2]));
    frame(16'h4020, 1'b0);
    frame(16'hC000, 1'b0);
    frame(16'h3100, 1'b0);
    push(16'h0FFF);
    frame(16'h0000, 1'b0);
    check("high alarm", 16'({gpPin.out[0], gpPin.oe[0]}), 16'h0003);
    frame(16'h9080, 1'b0);
    frame(16'h3000, 1'b0);
    frame(16'h0000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      frame(16'h0000, 1'b0);
      check("scan channel", 16'(seenCh), 16'((i + 1) % 3));
    end
    // A programming frame pair: the mode frame inside it must be swallowed
    frame(16'h8000, 1'b0);
    frame(16'h1000, 1'b0);
    frame(16'h0000, 1'b0);
    check("program frame kept", 16'(seenCh), 16'h0001);
    frame(16'h2000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      frame(16'h0000, 1'b0);
      check("auto one channel", 16'(seenCh), 16'(i));
    end
    frame(16'h420F, 1'b0);
    frame(16'h0000, 1'b0);
    check("pins after reset", 16'(gpPin), 16'h0000);
    check("frame starts", 16'(starts), 16'(frames));
    final_report();
  end
endmodule
